/* pdr_pkg.sv */
// Purpose: Shared constants and types for the duty-capture, hysteresis and ramp block.
// Assumes: 125 MHz system clock; 8-bit register port.
// Notes: Every offset, reset value and timing count lives here, with the mode, rate and hysteresis field positions.
package pdr_pkg;
    // ==========================================================
    // Clock and sample rates
    localparam int CLK_HZ = 125_000_000;
    localparam int SMP_HZ_SLOW = 800_000;
    localparam int SMP_HZ_MID = 4_000_000;
    localparam int SMP_HZ_FAST = 24_000_000;
    localparam logic [7:0] SMP_DIV_SLOW = 8'(CLK_HZ / SMP_HZ_SLOW);
    localparam logic [7:0] SMP_DIV_MID = 8'(CLK_HZ / SMP_HZ_MID);
    localparam logic [7:0] SMP_DIV_FAST = 8'(CLK_HZ / SMP_HZ_FAST);
    // No-pulse timeouts in microseconds, then in sample periods.
    localparam int TO_US_SLOW = 25_000;
    localparam int TO_US_MID = 3_000;
    localparam int TO_US_FAST = 600;
    localparam int TO_SMP_SLOW = TO_US_SLOW * (SMP_HZ_SLOW / 1000) / 1000;
    localparam int TO_SMP_MID = TO_US_MID * (SMP_HZ_MID / 1000) / 1000;
    localparam int TO_SMP_FAST = TO_US_FAST * (SMP_HZ_FAST / 1000) / 1000;
    // One microsecond in clock cycles.
    localparam int US_CYC = CLK_HZ / 1_000_000;
    // Time per ramp step in microseconds, one entry per ramp select setting.
    localparam logic [13:0] RAMP_US [8] = '{14'h0001, 14'h007D, 14'h00FA, 14'h01F4,
                                            14'h03E8, 14'h07D0, 14'h0FA0, 14'h1F40};
    // ==========================================================
    // Register map and fields
    localparam logic [7:0] ADDR_MODE = 8'h11;
    localparam logic [7:0] ADDR_PWM_CFG = 8'h12;
    localparam logic [7:0] ADDR_RAMP = 8'h14;
    localparam logic [7:0] ADDR_BRT_LO = 8'h18;
    localparam logic [7:0] ADDR_BRT_HI = 8'h19;
    localparam logic [7:0] ADDR_STAT = 8'h1A;
    localparam logic [7:0] ADDR_CODE = 8'h1B;
    localparam int MODE_LSB = 5;
    localparam int RATE_LSB = 6;
    localparam int HYS_LSB = 2;
    localparam logic [1:0] MODE_REG = 2'h0;
    localparam logic [1:0] MODE_PWM = 2'h1;
    localparam logic [1:0] MODE_MUL_RAMP = 2'h2;
    localparam logic [1:0] MODE_MUL_OUT = 2'h3;
    localparam logic [2:0] HYS_MAX = 3'h6;
    // ==========================================================
    // Types
    typedef enum logic [1:0] {PDR_IDLE = 2'b00, PDR_DIV = 2'b01} pdr_meas_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pdr_bus_req_t;
    typedef struct packed {
        logic s1; logic s2; logic lvl; logic [7:0] div; logic tick;
        logic [14:0] hi; logic [14:0] per; logic [14:0] to; logic tmo;
        pdr_meas_t st; logic [3:0] it; logic [15:0] rem; logic [14:0] dvs; logic [10:0] q;
        logic [10:0] duty; logic vld; logic [10:0] filt; logic up;
        logic [1:0] mode; logic [1:0] rate; logic [2:0] hys; logic [2:0] rsel;
        logic [2:0] lo; logic [10:0] brightness_code; logic [10:0] ramp; logic [13:0] rtmr;
        logic [6:0] us; logic ustick; logic [10:0] code; logic boost_off; logic [7:0] rdata;
    } pdr_state_t;
    // Everything clears at reset: register mode, slowest rate, no hysteresis.
    localparam pdr_state_t PDR_RST = '0;

    // Scales one 11-bit code by another taken as a fraction of full scale.
    function automatic logic [10:0] pdr_mul(input logic [10:0] a, input logic [10:0] b);
        logic [21:0] p;
        p = {11'h000, a} * {11'h000, b};
        return p[21:11];
    endfunction
endpackage

/* pdr_top.sv */
// Purpose: Duty-cycle capture, direction hysteresis, no-pulse timeout and code ramper.
// Assumes: pwm_in is asynchronous; register port is single-cycle, read data one cycle later.
// Notes: The ramped code, scaled by the duty code in MODE_MUL_OUT, drives the string sinks; boost_off shuts the boost stage.
`timescale 1ns/1ns
module pdr_top #(
    parameter int TO_SMP_SLOW_P = pdr_pkg::TO_SMP_SLOW,
    parameter int TO_SMP_MID_P = pdr_pkg::TO_SMP_MID,
    parameter int TO_SMP_FAST_P = pdr_pkg::TO_SMP_FAST,
    parameter int US_CYC_P = pdr_pkg::US_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire pdr_pkg::pdr_bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    input wire logic pwm_in,
    output logic [10:0] string_sink_current,
    output logic boost_off
);
    import pdr_pkg::*;

    // ==========================================================
    // Elaboration checks
    // Counters are 15 bits for timeouts and 7 bits for the microsecond tick.
    if (TO_SMP_SLOW_P < 1 || TO_SMP_SLOW_P > 32767 || TO_SMP_MID_P < 1 || TO_SMP_MID_P > 32767 ||
        TO_SMP_FAST_P < 1 || TO_SMP_FAST_P > 32767) begin : g_bad_to
        $error("timeout count out of range");
    end
    if (US_CYC_P < 1 || US_CYC_P > 128) begin : g_bad_us
        $error("microsecond divider out of range");
    end

    localparam logic [14:0] TO_LIM_SLOW = 15'(TO_SMP_SLOW_P);
    localparam logic [14:0] TO_LIM_MID = 15'(TO_SMP_MID_P);
    localparam logic [14:0] TO_LIM_FAST = 15'(TO_SMP_FAST_P);
    localparam logic [6:0] US_LAST = 7'(US_CYC_P - 1);

    pdr_state_t r_q;
    pdr_state_t r_d;
    logic [7:0] smp_lim;
    logic [14:0] to_lim;
    logic rise;
    logic [15:0] sh;
    logic qb;
    logic [2:0] hys_eff;
    logic [11:0] thr;
    logic [11:0] diff;
    logic [10:0] tgt;
    logic start;

    // ==========================================================
    // Next-state logic
    // All state is one record; this process computes its next value.
    always_comb begin
        r_d = r_q;
        r_d.s1 = pwm_in;
        r_d.s2 = r_q.s1;
        r_d.vld = 1'b0;
        r_d.rdata = 8'h00;
        start = 1'b0;
        sh = 16'h0000;
        qb = 1'b0;
        diff = 12'h000;

        // Sample clock derived from the system clock by an integer divider.
        case (r_q.rate)
            2'b00: begin
                smp_lim = SMP_DIV_SLOW;
                to_lim = TO_LIM_SLOW;
            end
            2'b01: begin
                smp_lim = SMP_DIV_MID;
                to_lim = TO_LIM_MID;
            end
            default: begin
                smp_lim = SMP_DIV_FAST;
                to_lim = TO_LIM_FAST;
            end
        endcase
        if (r_q.div >= smp_lim - 8'h01) begin
            r_d.div = 8'h00;
            r_d.tick = 1'b1;
        end else begin
            r_d.div = r_q.div + 8'h01;
            r_d.tick = 1'b0;
        end

        // Period and high-time counting, restarted on each sampled rising edge.
        rise = r_q.tick && r_q.s2 && !r_q.lvl;
        if (r_q.mode == MODE_REG) begin
            r_d.hi = 15'h0000;
            r_d.per = 15'h0000;
            r_d.to = 15'h0000;
            r_d.tmo = 1'b0;
            r_d.lvl = 1'b0;
        end else if (r_q.tick) begin
            r_d.lvl = r_q.s2;
            if (rise) begin
                // A period spanning a timeout is garbage, so it is not measured.
                start = !r_q.tmo && r_q.st == PDR_IDLE && r_q.per != 15'h0000;
                r_d.hi = 15'h0001;
                r_d.per = 15'h0001;
                r_d.to = 15'h0000;
                r_d.tmo = 1'b0;
            end else begin
                // Before the first edge the period is unknown, so period and high time do not count until one is seen; the timeout still counts.
                if (r_q.per != 15'h7FFF && r_q.per != 15'h0000) begin
                    r_d.per = r_q.per + 15'h0001;
                    r_d.hi = r_q.hi + {14'h0000, r_q.s2};
                end
                if (r_q.to >= to_lim) begin
                    r_d.tmo = 1'b1;
                end else begin
                    r_d.to = r_q.to + 15'h0001;
                end
            end
        end

        // Duty code = high * 2048 / period, one quotient bit per clock.
        case (r_q.st)
            PDR_IDLE: begin
                if (start) begin
                    r_d.st = PDR_DIV;
                    r_d.it = 4'h0;
                    r_d.rem = {1'b0, r_q.hi};
                    r_d.dvs = r_q.per;
                    r_d.q = 11'h000;
                end
            end
            PDR_DIV: begin
                sh = {r_q.rem[14:0], 1'b0};
                qb = sh >= {1'b0, r_q.dvs};
                r_d.rem = qb ? sh - {1'b0, r_q.dvs} : sh;
                r_d.q = {r_q.q[9:0], qb};
                r_d.it = r_q.it + 4'h1;
                if (r_q.it == 4'hA) begin
                    r_d.st = PDR_IDLE;
                    r_d.duty = {r_q.q[9:0], qb};
                    r_d.vld = 1'b1;
                end
            end
            default: r_d.st = PDR_IDLE;
        endcase

        // Direction hysteresis; the unused setting 111 behaves as 110.
        hys_eff = (r_q.hys > HYS_MAX) ? HYS_MAX : r_q.hys;
        thr = 12'h001 << hys_eff;
        if (r_q.vld) begin
            if (r_q.duty > r_q.filt) begin
                diff = {1'b0, r_q.duty} - {1'b0, r_q.filt};
                if (r_q.up || diff >= thr) begin
                    r_d.filt = r_q.duty;
                    r_d.up = 1'b1;
                end
            end else if (r_q.duty < r_q.filt) begin
                diff = {1'b0, r_q.filt} - {1'b0, r_q.duty};
                if (!r_q.up || diff >= thr) begin
                    r_d.filt = r_q.duty;
                    r_d.up = 1'b0;
                end
            end
        end

        // Register writes; the low brightness bits wait for the high byte.
        if (bus_req.wr) begin
            case (bus_req.addr)
                ADDR_MODE: r_d.mode = bus_req.wdata[MODE_LSB +: 2];
                ADDR_PWM_CFG: begin
                    r_d.rate = bus_req.wdata[RATE_LSB +: 2];
                    r_d.hys = bus_req.wdata[HYS_LSB +: 3];
                end
                ADDR_RAMP: r_d.rsel = bus_req.wdata[2:0];
                ADDR_BRT_LO: r_d.lo = bus_req.wdata[2:0];
                ADDR_BRT_HI: r_d.brightness_code = {bus_req.wdata, r_q.lo};
                default: ;
            endcase
        end

        // Ramp target per brightness mode.
        case (r_q.mode)
            MODE_PWM: tgt = r_q.filt;
            MODE_MUL_RAMP: tgt = pdr_mul(r_q.brightness_code, r_q.filt);
            default: tgt = r_q.brightness_code;
        endcase

        // Register reads answer one cycle later and read zero otherwise.
        if (bus_req.rd) begin
            case (bus_req.addr)
                ADDR_MODE: r_d.rdata = {1'b0, r_q.mode, 5'h00};
                ADDR_PWM_CFG: r_d.rdata = {r_q.rate, 1'b0, r_q.hys, 2'h0};
                ADDR_RAMP: r_d.rdata = {5'h00, r_q.rsel};
                ADDR_BRT_LO: r_d.rdata = {5'h00, r_q.lo};
                ADDR_BRT_HI: r_d.rdata = r_q.brightness_code[10:3];
                ADDR_STAT: r_d.rdata = {6'h00, r_q.ramp != tgt, r_q.tmo};
                ADDR_CODE: r_d.rdata = r_q.code[10:3];
                default: r_d.rdata = 8'h00;
            endcase
        end

        // Microsecond time base for the ramp step timer.
        if (r_q.us >= US_LAST) begin
            r_d.us = 7'h00;
            r_d.ustick = 1'b1;
        end else begin
            r_d.us = r_q.us + 7'h01;
            r_d.ustick = 1'b0;
        end

        // First step is taken at once, so a ramp lasts step time x (difference - 1).
        if (r_q.ramp != tgt) begin
            if (r_q.rtmr == 14'h0000) begin
                r_d.ramp = (tgt > r_q.ramp) ? r_q.ramp + 11'h001 : r_q.ramp - 11'h001;
                r_d.rtmr = RAMP_US[r_q.rsel];
            end else if (r_q.ustick) begin
                r_d.rtmr = r_q.rtmr - 14'h0001;
            end
        end else begin
            r_d.rtmr = 14'h0000;
        end

        // Registered outputs.
        r_d.code = (r_q.mode == MODE_MUL_OUT) ? pdr_mul(r_q.ramp, r_q.filt) : r_q.ramp;
        r_d.boost_off = r_q.tmo && r_q.mode != MODE_REG;
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r_q <= PDR_RST;
        end else begin
            r_q <= r_d;
        end
    end

    assign bus_rdata = r_q.rdata;
    assign string_sink_current = r_q.code;
    assign boost_off = r_q.boost_off;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_conv;
        (r_q.st == PDR_DIV) [*8] ##1 (r_q.st == PDR_DIV) [*3] ##1 r_q.vld;
    endsequence
    sequence s_rev_small;
        r_q.vld && r_q.duty > r_q.filt && !r_q.up && ({1'b0, r_q.duty} - {1'b0, r_q.filt}) < thr;
    endsequence

    AST_DIV_LEN: assert property (start |=> s_conv)
        else $error("duty conversion did not finish in eleven cycles");
    AST_HYS_HOLD: assert property (s_rev_small |=> $stable(r_q.filt))
        else $error("small reversal passed the hysteresis");
    AST_HYS_FOLLOW: assert property (r_q.vld && r_q.up && r_q.duty > r_q.filt
        |=> r_q.filt == $past(r_q.duty))
        else $error("same-direction change was not followed");
    AST_RAMP_ONE: assert property ($changed(r_q.ramp)
        |-> (r_q.ramp == $past(r_q.ramp) + 11'h001) || (r_q.ramp == $past(r_q.ramp) - 11'h001))
        else $error("ramp moved by more than one code");
    AST_RAMP_WAIT: assert property ($changed(r_q.ramp) |-> $past(r_q.rtmr) == 14'h0000)
        else $error("ramp stepped before its interval ended");
    AST_RAMP_FIRST: assert property (r_q.rtmr == 14'h0000 && r_q.ramp != tgt
        |=> $changed(r_q.ramp))
        else $error("ramp did not take its first step");
    AST_TIMEOUT: assert property (r_q.tick && r_q.mode != MODE_REG && !rise && r_q.to >= to_lim
        |=> r_q.tmo ##1 (r_q.boost_off || r_q.mode == MODE_REG))
        else $error("timeout did not switch the boost off");
    AST_MODE_REG: assert property (r_q.mode == MODE_REG [*2] |-> !r_q.boost_off && !r_q.tmo)
        else $error("pulse path active in register mode");
    // In pulse mode the ramper heads for the filtered duty code, whatever the register code says.
    AST_MODE_PWM: assert property (r_q.mode == MODE_PWM && r_q.rtmr == 14'h0000 && r_q.ramp > r_q.filt
        |=> r_q.ramp == $past(r_q.ramp) - 11'h001)
        else $error("pulse mode did not step toward the duty code");
    // In register mode the ramper heads for the register code, one step at a time.
    AST_REG_TARGET: assert property (r_q.mode == MODE_REG && r_q.rtmr == 14'h0000 && r_q.ramp < r_q.brightness_code
        |=> r_q.ramp == $past(r_q.ramp) + 11'h001)
        else $error("register mode did not step toward the register code");
    // A rate change lets the next tick come early from the new divider limit, so only slow-rate ticks are judged.
    AST_SLOW_RATE: assert property (r_q.tick && r_q.rate == 2'b00
        |=> (!r_q.tick || $past(r_q.rate) != 2'b00) [*8])
        else $error("slow sample rate ticks too often");
    // A pulse edge always clears the timeout, so the boost returns with the first pulse.
    AST_TMO_CLEAR: assert property (rise |=> !r_q.tmo)
        else $error("pulse edge did not clear the timeout");
endmodule

/* pdr_pwm_src.sv */
// Purpose: Model of the pulse-width brightness source that drives pwm_in.
// Assumes: Period and high time are whole clock counts; high time is taken at each period start, the period is compared every cycle.
// Notes: When disabled it finishes the running period and then rests low.
`timescale 1ns/1ns
module pdr_pwm_src (
    input wire logic clk,
    input wire logic en,
    input wire logic [15:0] per,
    input wire logic [15:0] hi,
    output logic pwm
);
    int cnt = 0;
    logic [15:0] hi_q = '0;
    initial pwm = 1'b0;
    // ==========================================================
    // Period generator
    // High time is taken only at a period start; the period setting is compared every cycle and acts at once.
    // The bench keeps the period well inside the active timeout while enabled.
    always @(posedge clk) begin
        if (cnt == 0 && !en) begin
            pwm <= 1'b0;
        end else begin
            if (cnt == 0) begin
                hi_q = hi;
            end
            pwm <= (cnt < hi_q);
            // A shrinking period must still wrap, hence the compare is not an equality.
            cnt = (cnt + 1 >= per) ? 0 : cnt + 1;
        end
    end
endmodule

/* test_pwm_duty_capture_hysteresis_ramp.sv */
// Purpose: Self-checking bench for the duty capture, hysteresis, timeout and ramp block.
// Assumes: Short timeouts and a 2-cycle microsecond keep the run brief.
// Notes: Read data are checked by a monitor against a queue of expected bytes.
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
    begin \
        checked++; \
        if ((got) !== (ex)) begin \
            miscompares++; \
            $display("mismatch %s expected %0h seen %0h", nm, ex, got); \
        end \
    end
module test_pwm_duty_capture_hysteresis_ramp;
    import pdr_pkg::*;
    localparam int US = 2;
    localparam int TOS[3] = '{10, 50, 300};
    localparam int DV[3] = '{SMP_DIV_SLOW, SMP_DIV_MID, SMP_DIV_FAST};
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    pdr_bus_req_t bus_req = '0;
    logic [7:0] bus_rdata;
    logic pwm_in;
    logic boost_off;
    logic [10:0] string_sink_current;
    logic src_en = 1'b0;
    logic [15:0] src_per = 16'h0500;
    logic [15:0] src_hi = 16'h0280;
    logic [7:0] exp_q[$];
    logic rd_d = 1'b0;
    logic ramp_chk = 1'b0;
    logic [10:0] sc_prev = '0;
    logic [7:0] exp_b;
    logic [10:0] step_b;
    int checked = 0;
    int miscompares = 0;

    // ==========================================================
    // Clock, design and source
    always #4 clk = ~clk;
    pdr_top #(.TO_SMP_SLOW_P(TOS[0]), .TO_SMP_MID_P(TOS[1]), .TO_SMP_FAST_P(TOS[2]), .US_CYC_P(US)) u_dut (
        .clk(clk), .reset_n(reset_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .pwm_in(pwm_in), .string_sink_current(string_sink_current), .boost_off(boost_off));
    pdr_pwm_src u_src (.clk(clk), .en(src_en), .per(src_per), .hi(src_hi), .pwm(pwm_in));

    // ==========================================================
    // Bus tasks and closing
    // Each strobe stands exactly one cycle; the next task waits an edge before raising it again.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        exp_q.push_back(e);
        @(posedge clk);
        bus_req.rd <= 1'b0;
    endtask
    task automatic wait_code(input logic [10:0] t, output int n);
        n = 0;
        while (string_sink_current !== t && n < 20000) begin
            @(posedge clk);
            n++;
        end
    endtask
    // The source changes only at period starts, so a few periods give a clean measurement.
    task automatic duty(input int h, input int e, input int k);
        src_hi <= 16'(h * 5);
        repeat (k * 1280) @(posedge clk);
        `CHK("duty code", 11'(e * 8), string_sink_current)
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Monitor
    // Read data stand only in the cycle after the strobe, so they are taken exactly there.
    always @(posedge clk) begin
        // The note is popped once, so a mismatch cannot shift the queue.
        if (rd_d) begin
            exp_b = exp_q.pop_front();
            `CHK("bus_rdata", exp_b, bus_rdata)
        end
        if (ramp_chk && sc_prev !== string_sink_current) begin
            step_b = string_sink_current - sc_prev;
            `CHK("step", 1'b1, step_b == 11'h001 || step_b == 11'h7FF)
        end
        rd_d <= bus_req.rd;
        sc_prev <= string_sink_current;
    end

    // Watchdog sized well above the roughly 86000 cycles the tests need.
    initial begin
        repeat (95000) @(posedge clk);
        miscompares++;
        give_verdict();
    end

    // ==========================================================
    // Main sequence
    initial begin
        int n;
        int h0;
        logic [10:0] a;
        logic [10:0] b;
        void'($urandom(32'h3589));
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        rd(ADDR_MODE, 8'h00);
        rd(ADDR_PWM_CFG, 8'h00);
        rd(ADDR_RAMP, 8'h00);
        wr(8'h13, 8'hFF);
        rd(8'h13, 8'h00);
        rd(ADDR_CODE, 8'h00);
        repeat (2000) @(posedge clk);
        `CHK("boost_off idle", 1'b0, boost_off)
        $display("test reset and map done");
        // Register mode ramps; the running source must not disturb the code.
        src_en <= 1'b1;
        wr(ADDR_BRT_LO, 8'h00);
        wr(ADDR_BRT_HI, 8'h80);
        wait_code(11'h400, n);
        `CHK("reg code", 11'h400, string_sink_current)
        ramp_chk = 1'b1;
        for (int r = 0; r < 8; r++) begin
            a = string_sink_current;
            b = r[0] ? a - 11'd2 : a + 11'd2;
            wr(ADDR_RAMP, 8'(r));
            wr(ADDR_BRT_LO, {5'h00, b[2:0]});
            wr(ADDR_BRT_HI, b[10:3]);
            wait_code(b, n);
            `CHK("ramp time", 1'b1, (n + 8 >= US * RAMP_US[r]) && (n <= US * RAMP_US[r] + 8))
            rd(ADDR_CODE, b[10:3]);
        end
        $display("test ramp rates done");
        // Pulse mode at the fast rate: 256 samples a period, so duty code is 8 per sample.
        // The source holds the first duty a full period before the pulse path opens.
        h0 = 64 + $urandom % 128;
        src_per <= 16'd1280;
        src_hi <= 16'(h0 * 5);
        wr(ADDR_RAMP, 8'h00);
        wr(ADDR_PWM_CFG, 8'h90);
        rd(ADDR_PWM_CFG, 8'h90);
        repeat (1280) @(posedge clk);
        wr(ADDR_MODE, 8'h20);
        wr(ADDR_BRT_HI, 8'h11);
        duty(h0, h0, 5);
        duty(h0 - 1, h0, 3);
        duty(h0 - 2, h0 - 2, 3);
        duty(h0 - 3, h0 - 3, 3);
        duty(h0 - 2, h0 - 3, 3);
        wr(ADDR_PWM_CFG, 8'h98);
        duty(h0 + 4, h0 - 3, 3);
        duty(h0 + 5, h0 + 5, 3);
        duty(h0 + 6, h0 + 6, 3);
        $display("test duty and hysteresis done");
        // Multiply modes: a half-scale register code halves the duty code.
        wr(ADDR_BRT_LO, 8'h00);
        wr(ADDR_BRT_HI, 8'h80);
        wr(ADDR_MODE, 8'h40);
        repeat (2000) @(posedge clk);
        `CHK("mul ramp code", 11'(4 * (h0 + 6)), string_sink_current)
        ramp_chk = 1'b0;
        wr(ADDR_MODE, 8'h60);
        rd(ADDR_STAT, 8'h02);
        repeat (2000) @(posedge clk);
        `CHK("mul out code", 11'(4 * (h0 + 6)), string_sink_current)
        rd(ADDR_STAT, 8'h00);
        $display("test multiply modes done");
        // Timeout at every rate, measured from the last rising edge.
        ramp_chk = 1'b0;
        for (int r = 0; r < 3; r++) begin
            src_per <= 16'(4 * DV[r]);
            src_hi <= 16'(2 * DV[r]);
            wr(ADDR_PWM_CFG, r == 0 ? 8'h00 : (r == 1 ? 8'h40 : 8'hC0));
            repeat (1200) @(posedge clk);
            `CHK("boost_off run", 1'b0, boost_off)
            @(posedge pwm_in);
            src_en <= 1'b0;
            n = 0;
            while (boost_off !== 1'b1 && n < 5000) begin
                @(posedge clk);
                n++;
            end
            `CHK("timeout", 1'b1, (n + 2 * DV[r] >= TOS[r] * DV[r]) && (n <= TOS[r] * DV[r] + 2 * DV[r] + 10))
            src_en <= 1'b1;
            repeat (12 * DV[r]) @(posedge clk);
            `CHK("boost_off back", 1'b0, boost_off)
        end
        $display("test timeout done");
        give_verdict();
    end
endmodule
